// [rtl/lasw_defines.svh]
// offsets, field positions and codes for the limit/alarm status word bank
`ifndef LASW_DEFINES_SVH
`define LASW_DEFINES_SVH

// object addressing
`define LASW_CLASS             8'h71
`define LASW_INST_MIN          8'h01
`define LASW_INST_MAX          8'h04

// attribute numbers (register offsets)
`define LASW_ATTR_LIMIT_STATE  8'h08
`define LASW_ATTR_LIMIT_CLEAR  8'h09
`define LASW_ATTR_HI_SETPOINT  8'h0a
`define LASW_ATTR_CUR_MONITOR  8'h0b
`define LASW_ATTR_ALARM_STATE  8'h0c
`define LASW_ATTR_ALARM_CTRL   8'h0d

// field positions inside the 32-bit word
`define LASW_DATA_LSB          16
`define LASW_SP_MSB            28
`define LASW_SP_LSB            16
`define LASW_SP_INERR_BIT      29
`define LASW_SP_LIMCLR_BIT     30
`define LASW_RMS_MSB           26
`define LASW_RMS_LSB           16
`define LASW_CERR_MSB          28
`define LASW_CERR_LSB          27
`define LASW_HERR_MSB          30
`define LASW_HERR_LSB          29

// two-bit state codes
`define LASW_ST_NONE           2'h0
`define LASW_ST_LOW            2'h1
`define LASW_ST_HIGH           2'h2

// reset values
`define LASW_SP_RESET          13'h0000

`endif

// [rtl/lasw_pkg.sv]
// types shared by the limit/alarm status word bank
package lasw_pkg;

  // one attribute access from the network side
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  cls;
    logic [7:0]  inst;
    logic [7:0]  attr;
    logic [31:0] wdata;
  } lasw_req_t;

  // answer to one access
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [31:0] rdata;
  } lasw_rsp_t;

  // current monitor sample from the current_sense_transformer front end
  typedef struct packed {
    logic [1:0]  heater_err;
    logic [1:0]  current_err;
    logic [10:0] rms;
  } lasw_cur_t;

endpackage

// [rtl/lasw_limit_latch.sv]
// latched two-bit limit state for eight instances
module lasw_limit_latch
  import lasw_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic           clock,
  input  wire logic           rst,
  input  wire logic           ce,
  input  wire logic [N-1:0]   set_low,
  input  wire logic [N-1:0]   set_high,
  input  wire logic [N-1:0]   clr,
  output logic      [2*N-1:0] state_ff
);
`include "lasw_defines.svh"

  logic [2*N-1:0] nxt_state;

  // an event in the clearing cycle wins, so no trip is lost
  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < N; i++) begin
      if (set_high[i]) begin
        nxt_state[2*i +: 2] = `LASW_ST_HIGH;
      end else if (set_low[i]) begin
        nxt_state[2*i +: 2] = `LASW_ST_LOW;
      end else if (clr[i]) begin
        nxt_state[2*i +: 2] = `LASW_ST_NONE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  a_limit_set_high: assert property (@(posedge clock) disable iff (rst)
    ce && set_high[0] |=> state_ff[1:0] == 2'h2)
    else $error("limit high event not latched");

  a_limit_clear: assert property (@(posedge clock) disable iff (rst)
    ce && clr[N-1] && !set_low[N-1] && !set_high[N-1] |=> state_ff[2*N-1 -: 2] == 2'h0)
    else $error("limit clear not applied");

endmodule

// [rtl/lasw_cmd_pulse.sv]
// one-cycle action pulses from write-one command bits
module lasw_cmd_pulse
  import lasw_pkg::*;
#(
  parameter int W = 17
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         fire,
  input  wire logic [W-1:0] bits,
  output logic      [W-1:0] pulse_ff
);

  logic [W-1:0] nxt_pulse;

  // a written zero gives no pulse; pulses last one enabled cycle
  always_comb begin
    nxt_pulse = fire ? bits : '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_ff <= '0;
    end else if (ce) begin
      pulse_ff <= nxt_pulse;
    end
  end

  a_pulse_drop: assert property (@(posedge clock) disable iff (rst)
    ce && !fire |=> pulse_ff == '0)
    else $error("action pulse outlived its write");

endmodule

// [rtl/lasw_status_words.sv]
// attribute bank for limit, current monitor and alarm words
// Summary of operation
// - limit state as two-bit pairs per instance
// - limit clear word: spare and clear-limit bits
// - high set point is signed 13-bit, bits 16-28
// - bit 29 one clears latched input error
// - bit 30 one clears limit condition
// - RMS current unsigned 11 bits, bits 16-26
// - current fault code in bits 27-28
// - heater fault code in bits 29-30
// - alarm state as two-bit pairs per instance
// - alarm word: clear upper, silence lower, one acts
// - alarm control word readable and writable
// - clear-limit bit one clears that limit
module lasw_status_words
  import lasw_pkg::*;
#(
  parameter int NPAIR = 8
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire lasw_req_t          req,
  output lasw_rsp_t               rsp_ff,
  input  wire logic [NPAIR-1:0]   limit_low_evt,
  input  wire logic [NPAIR-1:0]   limit_high_evt,
  input  wire logic [2*NPAIR-1:0] alarm_state_in,
  input  wire lasw_cur_t          cur_in,
  output logic      [12:0]        high_setpoint_ff,
  output logic      [2*NPAIR-1:0] limit_state_ff,
  output logic                    clear_input_err_ff,
  output logic      [NPAIR-1:0]   alarm_clear_ff,
  output logic      [NPAIR-1:0]   alarm_silence_ff
);
`include "lasw_defines.svh"

  // attribute test, used by every decode term
  function automatic logic attr_is(input logic [7:0] a, input logic [7:0] want);
    return a == want;
  endfunction

  // even (lower) or odd (upper) bit of each pair in the data half
  function automatic logic [NPAIR-1:0] pair_bits(input logic [31:0] w, input int hi);
    logic [NPAIR-1:0] r;
    r = '0;
    for (int i = 0; i < NPAIR; i++) begin
      r[i] = w[`LASW_DATA_LSB + 2*i + hi];
    end
    return r;
  endfunction

  logic                 acc;
  logic                 addr_ok;
  logic                 attr_known;
  logic                 attr_ro;
  logic                 bad;
  logic                 wr_ok;
  logic                 fire_limclr;
  logic                 fire_sp;
  logic                 fire_alarm;
  logic [NPAIR-1:0]     limit_clr;
  logic [2*NPAIR+0:0]   cmd_bits;
  logic [2*NPAIR+0:0]   cmd_pulse;
  lasw_rsp_t            nxt_rsp;
  logic [12:0]          nxt_setpoint;
  logic [31:0]          rd_word;

  // address check: the master addresses class 0x71, instances 1 to 4
  always_comb begin
    acc        = ce && req.valid;
    addr_ok    = (req.cls == `LASW_CLASS) &&
                 (req.inst >= `LASW_INST_MIN) && (req.inst <= `LASW_INST_MAX);
    attr_known = attr_is(req.attr, `LASW_ATTR_LIMIT_STATE) ||
                 attr_is(req.attr, `LASW_ATTR_LIMIT_CLEAR) ||
                 attr_is(req.attr, `LASW_ATTR_HI_SETPOINT) ||
                 attr_is(req.attr, `LASW_ATTR_CUR_MONITOR) ||
                 attr_is(req.attr, `LASW_ATTR_ALARM_STATE) ||
                 attr_is(req.attr, `LASW_ATTR_ALARM_CTRL);
    // writes to read-only words are refused, not silently dropped
    attr_ro    = attr_is(req.attr, `LASW_ATTR_LIMIT_STATE) ||
                 attr_is(req.attr, `LASW_ATTR_CUR_MONITOR) ||
                 attr_is(req.attr, `LASW_ATTR_ALARM_STATE);
    bad        = !addr_ok || !attr_known || (req.write && attr_ro);
    wr_ok      = acc && req.write && !bad;
  end

  // write decode for the three action words
  always_comb begin
    fire_limclr = wr_ok && attr_is(req.attr, `LASW_ATTR_LIMIT_CLEAR);
    fire_sp     = wr_ok && attr_is(req.attr, `LASW_ATTR_HI_SETPOINT);
    fire_alarm  = wr_ok && attr_is(req.attr, `LASW_ATTR_ALARM_CTRL);
    // spare (odd) bits of the limit clear word are never looked at
    limit_clr   = fire_limclr ? pair_bits(req.wdata, 0) : '0;
    // a limit clear through the set point word acts on every pair
    if (fire_sp && req.wdata[`LASW_SP_LIMCLR_BIT]) begin
      limit_clr = '1;
    end
  end

  // set point register; bit 31 is spare and ignored
  always_comb begin
    nxt_setpoint = high_setpoint_ff;
    if (fire_sp) begin
      nxt_setpoint = req.wdata[`LASW_SP_MSB:`LASW_SP_LSB];
    end
  end

  // command vector: latched input error clear, then clears, then silences
  always_comb begin
    cmd_bits = '0;
    if (fire_sp) begin
      cmd_bits[2*NPAIR] = req.wdata[`LASW_SP_INERR_BIT];
    end
    if (fire_alarm) begin
      cmd_bits[2*NPAIR-1:NPAIR] = pair_bits(req.wdata, 1);
      cmd_bits[NPAIR-1:0]       = pair_bits(req.wdata, 0);
    end
  end

  // read word assembly; the low half and spares always read zero
  always_comb begin
    rd_word = '0;
    unique case (1'b1)
      attr_is(req.attr, `LASW_ATTR_LIMIT_STATE): begin
        rd_word[31:16] = limit_state_ff;
      end
      attr_is(req.attr, `LASW_ATTR_HI_SETPOINT): begin
        rd_word[`LASW_SP_MSB:`LASW_SP_LSB] = high_setpoint_ff;
      end
      attr_is(req.attr, `LASW_ATTR_CUR_MONITOR): begin
        rd_word[`LASW_RMS_MSB:`LASW_RMS_LSB]   = cur_in.rms;
        rd_word[`LASW_CERR_MSB:`LASW_CERR_LSB] = cur_in.current_err;
        rd_word[`LASW_HERR_MSB:`LASW_HERR_LSB] = cur_in.heater_err;
      end
      attr_is(req.attr, `LASW_ATTR_ALARM_STATE): begin
        rd_word[31:16] = alarm_state_in;
      end
      default: begin
        // action words hold no state, so they read back as zero
        rd_word = '0;
      end
    endcase
  end

  // answer one cycle after each access, refused ones included
  always_comb begin
    nxt_rsp       = '0;
    nxt_rsp.valid = req.valid;
    nxt_rsp.error = req.valid && bad;
    if (req.valid && !bad && !req.write) begin
      nxt_rsp.rdata = rd_word;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rsp_ff           <= '0;
      high_setpoint_ff <= `LASW_SP_RESET;
    end else if (ce) begin
      rsp_ff           <= nxt_rsp;
      high_setpoint_ff <= nxt_setpoint;
    end
  end

  // per-instance limit state with set-over-clear priority
  lasw_limit_latch #(
    .N (NPAIR)
  ) u_limit (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .set_low  (limit_low_evt),
    .set_high (limit_high_evt),
    .clr      (limit_clr),
    .state_ff (limit_state_ff)
  );

  // one registered pulse per written one
  lasw_cmd_pulse #(
    .W (2*NPAIR+1)
  ) u_cmd (
    .clock    (clock),
    .rst      (rst),
    .ce       (ce),
    .fire     (fire_sp || fire_alarm),
    .bits     (cmd_bits),
    .pulse_ff (cmd_pulse)
  );

  assign clear_input_err_ff = cmd_pulse[2*NPAIR];
  assign alarm_clear_ff     = cmd_pulse[2*NPAIR-1:NPAIR];
  assign alarm_silence_ff   = cmd_pulse[NPAIR-1:0];

  a_bad_class: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && req.cls != 8'h71 |=> rsp_ff.valid && rsp_ff.error)
    else $error("wrong class not refused");

  a_bad_inst: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && (req.inst == 8'h00 || req.inst > 8'h04) |=> rsp_ff.error)
    else $error("instance out of range not refused");

  a_sp_load: assert property (@(posedge clock) disable iff (rst)
    ce && fire_sp |=> high_setpoint_ff == $past(req.wdata[28:16]))
    else $error("set point not loaded");

  // the pulse may only stand on if the enable was low or another clear came right behind
  a_inerr_clear: assert property (@(posedge clock) disable iff (rst)
    ce && fire_sp && req.wdata[29] |=> clear_input_err_ff ##1
    (!clear_input_err_ff || !$past(ce) || $past(fire_sp && req.wdata[29])))
    else $error("latched error clear pulse wrong");

  a_limclr_all: assert property (@(posedge clock) disable iff (rst)
    ce && fire_sp && req.wdata[30] && limit_low_evt == '0 && limit_high_evt == '0
    |=> limit_state_ff == '0)
    else $error("limit clear through set point failed");

  a_rms_read: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && !req.write && addr_ok && req.attr == 8'h0b
    |=> rsp_ff.rdata[26:16] == $past(cur_in.rms) && rsp_ff.rdata[15:0] == 16'h0000)
    else $error("RMS current field wrong");

  a_fault_read: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && !req.write && addr_ok && req.attr == 8'h0b
    |=> rsp_ff.rdata[30:27] == $past({cur_in.heater_err, cur_in.current_err}))
    else $error("fault code fields wrong");

  a_alarm_read: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && !req.write && addr_ok && req.attr == 8'h0c
    |=> rsp_ff.rdata == {$past(alarm_state_in), 16'h0000})
    else $error("alarm state word wrong");

  a_alarm_ctrl: assert property (@(posedge clock) disable iff (rst)
    ce && fire_alarm && req.wdata[31] |=> alarm_clear_ff[NPAIR-1] &&
    alarm_silence_ff[NPAIR-1] == $past(req.wdata[30]))
    else $error("alarm clear bit mapped wrong");

  a_spare_read: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && !req.write && req.attr == 8'h0a |=> rsp_ff.rdata[31:29] == 3'h0)
    else $error("spare bits not zero");

  // bus-side checks: one answer per access, refusals carry no data
  a_resp_once: assert property (@(posedge clock) disable iff (rst)
    ce && !req.valid |=> !rsp_ff.valid)
    else $error("answer without access");

  a_err_nodata: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && bad |=> rsp_ff.rdata == 32'h0)
    else $error("refused access returned data");

  a_ro_write: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && req.write && req.attr == 8'h0b |=> rsp_ff.error)
    else $error("write to current monitor word accepted");

  a_limword_write: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && req.write && addr_ok && req.attr == 8'h09
    |=> rsp_ff.valid && !rsp_ff.error)
    else $error("limit clear word write refused");

  a_ctrl_readback: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && !req.write && addr_ok && req.attr == 8'h0d
    |=> rsp_ff.valid && !rsp_ff.error && rsp_ff.rdata == 32'h0)
    else $error("alarm control word read refused");

  a_limit_read: assert property (@(posedge clock) disable iff (rst)
    ce && req.valid && !req.write && addr_ok && req.attr == 8'h08
    |=> rsp_ff.rdata == {$past(limit_state_ff), 16'h0000})
    else $error("limit state word wrong");

  // limit clear word: a one clears the pair, a zero leaves it
  a_limclr_word: assert property (@(posedge clock) disable iff (rst)
    ce && fire_limclr && req.wdata[16] && !limit_low_evt[0] && !limit_high_evt[0]
    |=> limit_state_ff[1:0] == 2'h0)
    else $error("clear-limit bit not applied");

  a_limclr_zero: assert property (@(posedge clock) disable iff (rst)
    ce && fire_limclr && !req.wdata[16] && !limit_low_evt[0] && !limit_high_evt[0]
    |=> limit_state_ff[1:0] == $past(limit_state_ff[1:0]))
    else $error("zero clear-limit bit acted");

  // set point word: untouched bits and zeros change nothing
  a_sp_hold: assert property (@(posedge clock) disable iff (rst)
    ce && !fire_sp |=> $stable(high_setpoint_ff))
    else $error("set point changed without a write");

  a_inerr_zero: assert property (@(posedge clock) disable iff (rst)
    ce && fire_sp && !req.wdata[29] |=> !clear_input_err_ff)
    else $error("error clear pulse from a zero bit");

  a_sp_keep_limit: assert property (@(posedge clock) disable iff (rst)
    ce && fire_sp && !req.wdata[30] && limit_low_evt == '0 && limit_high_evt == '0
    |=> limit_state_ff == $past(limit_state_ff))
    else $error("limit changed by a zero clear bit");

  // alarm word: lower bit silences, upper bit clears, zeros do nothing
  a_alarm_silence: assert property (@(posedge clock) disable iff (rst)
    ce && fire_alarm && req.wdata[16]
    |=> alarm_silence_ff[0] && alarm_clear_ff[0] == $past(req.wdata[17]))
    else $error("alarm silence bit mapped wrong");

  a_alarm_ignore: assert property (@(posedge clock) disable iff (rst)
    ce && fire_alarm && req.wdata[31:16] == 16'h0000
    |=> alarm_clear_ff == '0 && alarm_silence_ff == '0)
    else $error("alarm action from zero bits");

  // a stalled enable must keep the alarm clear and silence pulses where they were
  a_pulse_freeze: assert property (@(posedge clock) disable iff (rst)
    !ce |=> $stable(alarm_clear_ff) && $stable(alarm_silence_ff))
    else $error("action pulse moved while disabled");

endmodule

// [verification/lasw_master_model.sv]
// network master model issuing attribute accesses
module lasw_master_model
  import lasw_pkg::*;
(
  input  wire logic clock,
  output lasw_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // strobe one cycle, then scramble released fields so stale values never match
  task automatic access(input logic w, input logic [7:0] c, input logic [7:0] n,
                        input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{valid: 1'b1, write: w, cls: c, inst: n, attr: a, wdata: d};
    @(posedge clock);
    req <= '{valid: 1'b0, write: ~w, cls: ~c, inst: ~n, attr: ~a, wdata: ~d};
  endtask
endmodule

// [verification/lasw_status_words_tb.sv]
// self-checking bench for the limit/alarm status word bank
module lasw_status_words_tb;
  import lasw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        rdv;
    logic        err;
    logic [31:0] rd;
    logic [7:0]  aclr;
    logic [7:0]  asil;
    logic        cie;
  } lasw_exp_t;

  logic        clock;
  logic        rst;
  logic        ce;
  lasw_req_t   req;
  lasw_rsp_t   rsp_ff;
  logic [7:0]  limit_low_evt;
  logic [7:0]  limit_high_evt;
  logic [15:0] alarm_state_in;
  lasw_cur_t   cur_in;
  logic [12:0] high_setpoint_ff;
  logic [15:0] limit_state_ff;
  logic        clear_input_err_ff;
  logic [7:0]  alarm_clear_ff;
  logic [7:0]  alarm_silence_ff;
  logic [15:0] exp_lim;
  logic [31:0] wd;
  logic [7:0]  lo;
  logic [7:0]  hi;
  lasw_exp_t   got;
  lasw_exp_t   exp_q[$];
  int          n_mismatch = 0;
  int          compares = 0;
  int          seed = 75231;
  // refused accesses: {write, class, instance, attribute}
  logic [24:0] bad [8] = '{25'h0700108, 25'h0710008, 25'h071050b, 25'h0710107,
                           25'h071010e, 25'h1710108, 25'h171010b, 25'h171010c};

  lasw_status_words #(.NPAIR(8)) lasw_status_words_i (
    .clock              (clock),
    .rst                (rst),
    .ce                 (ce),
    .req                (req),
    .rsp_ff             (rsp_ff),
    .limit_low_evt      (limit_low_evt),
    .limit_high_evt     (limit_high_evt),
    .alarm_state_in     (alarm_state_in),
    .cur_in             (cur_in),
    .high_setpoint_ff   (high_setpoint_ff),
    .limit_state_ff     (limit_state_ff),
    .clear_input_err_ff (clear_input_err_ff),
    .alarm_clear_ff     (alarm_clear_ff),
    .alarm_silence_ff   (alarm_silence_ff)
  );

  lasw_master_model lasw_master_model_i (
    .clock (clock),
    .req   (req)
  );

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic lasw_exp_t ex(logic e, logic [31:0] r, logic [7:0] c = 8'h00,
                                   logic [7:0] s = 8'h00, logic i = 1'b0);
    return '{1'b1, e, r, c, s, i};
  endfunction

  function automatic logic [7:0] inst_any();
    return {6'h00, 2'($random(seed))} + 8'h01;
  endfunction

  // note the answer, then hand the access to the master; write data is not echoed
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, lasw_exp_t e,
                     logic [7:0] c = 8'h71, logic [7:0] n = 8'hff);
    e.rdv = !w || e.err;
    exp_q.push_back(e);
    // 8'hff asks for any legal instance; instance zero must stay a refused case
    lasw_master_model_i.access(w, c, (n == 8'hff) ? inst_any() : n, a, d);
  endtask

  // compare every answer with the oldest outstanding note
  always @(posedge clock) begin
    if (rsp_ff.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("answer count", 32'h0, 32'h1);
      end else begin
        got = exp_q.pop_front();
        chk("error flag", 32'(got.err), 32'(rsp_ff.error));
        if (got.rdv) begin
          chk("read data", got.rd, rsp_ff.rdata);
        end
        chk("alarm clear", 32'(got.aclr), 32'(alarm_clear_ff));
        chk("alarm silence", 32'(got.asil), 32'(alarm_silence_ff));
        chk("input error clear", 32'(got.cie), 32'(clear_input_err_ff));
      end
    end
  end

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clock);
    chk("run length", 32'h0, 32'h1);
    finish_test();
  end

  // main sequence: events, refused accesses, every word read and written
  initial begin
    rst            = 1'b1;
    ce             = 1'b1;
    limit_low_evt  = 8'h00;
    limit_high_evt = 8'h00;
    alarm_state_in = 16'h0000;
    cur_in         = '0;
    exp_lim        = 16'h0000;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    acc(1'b0, 8'h0a, 32'h0, ex(1'b0, 32'h0));
    for (int it = 0; it < 6; it++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      @(posedge clock);
      limit_low_evt  <= lo;
      limit_high_evt <= hi;
      @(posedge clock);
      limit_low_evt  <= 8'h00;
      limit_high_evt <= 8'h00;
      for (int k = 0; k < 8; k++) begin
        if (hi[k] || lo[k]) begin
          exp_lim[2*k+:2] = hi[k] ? 2'h2 : 2'h1;
        end
      end
      for (int b = 0; b < 8 && it == 0; b++) begin
        acc(bad[b][24], bad[b][7:0], 32'($random(seed)), ex(1'b1, 32'h0), bad[b][23:16],
            bad[b][15:8]);
      end
      acc(1'b0, 8'h08, 32'h0, ex(1'b0, {exp_lim, 16'h0000}));
      chk("limit state", 32'(exp_lim), 32'(limit_state_ff));
      wd = 32'($random(seed));
      acc(1'b1, 8'h09, wd, ex(1'b0, 32'h0));
      for (int k = 0; k < 8; k++) begin
        if (wd[16+2*k]) begin
          exp_lim[2*k+:2] = 2'h0;
        end
      end
      acc(1'b0, 8'h09, 32'h0, ex(1'b0, 32'h0));
      acc(1'b0, 8'h08, 32'h0, ex(1'b0, {exp_lim, 16'h0000}));
      wd = 32'($random(seed));
      acc(1'b1, 8'h0a, wd, ex(1'b0, 32'h0, 8'h00, 8'h00, wd[29]));
      exp_lim = wd[30] ? 16'h0000 : exp_lim;
      acc(1'b0, 8'h0a, 32'h0, ex(1'b0, {3'h0, wd[28:16], 16'h0000}));
      chk("set point", 32'(wd[28:16]), 32'(high_setpoint_ff));
      acc(1'b0, 8'h08, 32'h0, ex(1'b0, {exp_lim, 16'h0000}));
      alarm_state_in <= 16'($random(seed));
      cur_in <= '{heater_err: 2'(it % 3), current_err: 2'((it + 1) % 3),
                  rms: 11'($random(seed))};
      @(posedge clock);
      acc(1'b0, 8'h0c, 32'h0, ex(1'b0, {alarm_state_in, 16'h0000}));
      acc(1'b0, 8'h0b, 32'h0, ex(1'b0, {1'b0, cur_in, 16'h0000}));
      wd = 32'($random(seed));
      for (int k = 0; k < 8; k++) begin
        lo[k] = wd[17+2*k];
        hi[k] = wd[16+2*k];
      end
      acc(1'b1, 8'h0d, wd, ex(1'b0, 32'h0, lo, hi));
      acc(1'b0, 8'h0d, 32'h0, ex(1'b0, 32'h0));
      acc(1'b1, 8'h09, 32'h55550000, ex(1'b0, 32'h0));
      exp_lim = 16'h0000;
    end
    // events while the enable is low must leave the latched state alone
    @(posedge clock);
    ce             <= 1'b0;
    limit_high_evt <= 8'hff;
    repeat (2) @(posedge clock);
    ce             <= 1'b1;
    limit_high_evt <= 8'h00;
    acc(1'b0, 8'h08, 32'h0, ex(1'b0, 32'h0));
    repeat (4) @(posedge clock);
    if (exp_q.size() != 0) begin
      chk("answers outstanding", 32'h0, 32'(exp_q.size()));
    end
    finish_test();
  end
endmodule
